// ---- core/owr_device.sv ----
// Purpose: receiver end of the one-wire brightness command link
// Assumes: line pulled high externally; single 125 MHz clock
// Notes: an accepted frame updates brightness once, then may acknowledge
// Notes on behaviour
// - master sends 24 bits, lsb first
// - master holds line high 2 us before start
// - line already high: first fall is bit one
// - low 2 us after frame ends it
// - longer low gives 0, longer high gives 1; the device reads 1 only when high lasts at least twice low
// - bit spans falling edge to falling edge
// - acknowledge needs request, address match, 24 bits
// - after validation delay pull low, max 512 us
// - master holds low, then releases and samples
// - sampled low means command received
// - master stays off line during acknowledge
// - push-pull master never requests acknowledge
// - bit 10 requests acknowledge
// - bits 8..0 are new brightness
// - bits 23..16 must equal address 0x8F
// - master sends zeros in unused bits
`timescale 1ns/1ns
`default_nettype none
module owr_device (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	owr_link_if.device link,
	output logic [8:0] brightness,
	output logic frame_ok,
	output logic ack_busy
);
	import owr_pkg::*;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_BITS = 4'b0010,
		ST_VAL = 4'b0100,
		ST_ACK = 4'b1000
	} owr_dst_t;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
	endfunction

	function automatic logic frame_match(input logic [23:0] w);
		frame_match = (w[ADDR_LSB_POS +: 8] == DEV_ADDR);
	endfunction

	logic line_s;
	logic fall;
	owr_dst_t st_q;
	logic [15:0] low_q;
	logic [15:0] high_q;
	logic [23:0] sh_q;
	logic [4:0] nbits_q;
	logic seen_fall_q;
	logic [8:0] bright_q;
	logic ok_q;
	logic pd_q;
	logic [16:0] tmr_q;
	logic bit_val;
	logic end_of_stream;

	// *****************************
	// line input
	// *****************************
	owr_sync_edge u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.din(link.line),
		.dout(line_s),
		.fall(fall)
	);

	// a bit reads 1 when its high phase lasts at least twice its low phase
	assign bit_val = (high_q >= {low_q[14:0], 1'b0}) ? 1'b1 : 1'b0;
	assign end_of_stream = !line_s && (low_q >= 16'(EOS_CYC));

	// *****************************
	// phase counters
	// *****************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_q <= 16'h0000;
			high_q <= 16'h0000;
		end else if (ce) begin
			if (fall) begin
				low_q <= 16'h0001;
				high_q <= 16'h0000;
			end else if (line_s) begin
				high_q <= sat_inc(high_q);
			end else begin
				low_q <= sat_inc(low_q);
			end
		end
	end

	// *****************************
	// frame state
	// *****************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			sh_q <= 24'h000000;
			nbits_q <= BIT_CNT_ZERO;
			seen_fall_q <= 1'b0;
			tmr_q <= 17'h00000;
		end else if (ce) begin
			case (st_q)
				ST_IDLE: begin
					nbits_q <= BIT_CNT_ZERO;
					seen_fall_q <= 1'b0;
					if (fall) begin
						st_q <= ST_BITS;
					end
				end
				ST_BITS: begin
					// a bit closes only at the next falling edge
					if (fall) begin
						if (nbits_q != BIT_CNT_FULL) begin
							sh_q <= {bit_val, sh_q[23:1]};
							nbits_q <= nbits_q + 5'h01;
						end else begin
							// a fall beyond the 24th bit marks the frame as too long
							seen_fall_q <= 1'b1;
						end
					end else if (end_of_stream) begin
						// eos starts at the last fall, so the delay already runs
						tmr_q <= 17'(EOS_CYC);
						if (nbits_q == BIT_CNT_FULL && !seen_fall_q && frame_match(sh_q) &&
							sh_q[ACK_REQ_POS]) begin
							st_q <= ST_VAL;
						end else begin
							st_q <= ST_IDLE;
						end
					end
				end
				ST_VAL: begin
					tmr_q <= tmr_q + 17'h00001;
					if (tmr_q >= 17'(ACK_VAL_CYC)) begin
						tmr_q <= 17'h00000;
						st_q <= ST_ACK;
					end
				end
				ST_ACK: begin
					tmr_q <= tmr_q + 17'h00001;
					if (tmr_q >= 17'(ACK_PULSE_CYC - 1)) begin
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// *****************************
	// brightness and acknowledge outputs
	// *****************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bright_q <= BRIGHT_RST;
			ok_q <= 1'b0;
		end else if (ce) begin
			ok_q <= 1'b0;
			if (st_q == ST_BITS && !fall && end_of_stream && nbits_q == BIT_CNT_FULL && !seen_fall_q &&
				frame_match(sh_q)) begin
				bright_q <= sh_q[BRIGHT_MSB_POS:BRIGHT_LSB_POS];
				ok_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pd_q <= 1'b0;
		end else if (ce) begin
			pd_q <= (st_q == ST_ACK) && (tmr_q < 17'(ACK_PULSE_CYC - 1));
		end
	end

	assign link.dev_o = 1'b0;
	assign link.dev_oe_n = !pd_q;
	assign brightness = bright_q;
	assign frame_ok = ok_q;
	assign ack_busy = pd_q;
endmodule
`default_nettype wire

// ---- core/owr_link_if.sv ----
// Purpose: open-drain one-wire line between master and receiver
// Assumes: external pull-up when nobody pulls low
// Notes: an output enable low means that end drives its output value
`timescale 1ns/1ns
`default_nettype none
interface owr_link_if;
	logic mst_o;
	logic mst_oe_n;
	logic dev_o;
	logic dev_oe_n;
	logic line;
	assign line = (!mst_oe_n && !mst_o) ? 1'b0 : (!dev_oe_n && !dev_o) ? 1'b0 : 1'b1;
	modport master (output mst_o, output mst_oe_n, input line);
	modport device (output dev_o, output dev_oe_n, input line);
endinterface
`default_nettype wire

// ---- core/owr_master.sv ----
// Purpose: master end that sends one 24-bit brightness command
// Assumes: open-drain drive; line pulled high externally
// Notes: bit time fixed; one third low or high per bit
`timescale 1ns/1ns
`default_nettype none
module owr_master (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	owr_link_if.master link,
	input wire logic send,
	input wire logic [8:0] level,
	input wire logic ack_req,
	output logic busy,
	output logic acked,
	output logic done
);
	import owr_pkg::*;
	typedef enum logic [5:0] {
		MS_IDLE = 6'b000001,
		MS_START = 6'b000010,
		MS_BIT = 6'b000100,
		MS_EOS = 6'b001000,
		MS_SAMP = 6'b010000,
		MS_WAIT = 6'b100000
	} owr_mst_t;
	owr_mst_t st_q;
	logic [23:0] w_q;
	logic [4:0] n_q;
	logic [16:0] t_q;
	logic drv_low_q;
	logic busy_q;
	logic acked_q;
	logic done_q;
	logic [16:0] low_len;
	logic s1_q;
	logic s2_q;
	// zero in unused bits; request only because this drive is open drain
	assign low_len = w_q[0] ? 17'(BIT_CYC / 3) : 17'(BIT_CYC - BIT_CYC / 3);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else if (ce) begin
			s1_q <= link.line;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= MS_IDLE;
			w_q <= 24'h000000;
			n_q <= BIT_CNT_ZERO;
			t_q <= 17'h00000;
			drv_low_q <= 1'b0;
			busy_q <= 1'b0;
			acked_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= 1'b0;
			t_q <= t_q + 17'h00001;
			case (st_q)
				MS_IDLE: begin
					drv_low_q <= 1'b0;
					t_q <= 17'h00000;
					if (send) begin
						w_q <= {DEV_ADDR, 5'h00, ack_req, 1'b0, level};
						n_q <= BIT_CNT_ZERO;
						busy_q <= 1'b1;
						acked_q <= 1'b0;
						st_q <= MS_START;
					end
				end
				MS_START: begin
					if (t_q >= 17'(START_CYC)) begin
						t_q <= 17'h00000;
						drv_low_q <= 1'b1;
						st_q <= MS_BIT;
					end
				end
				MS_BIT: begin
					if (t_q == low_len - 17'h00001) begin
						drv_low_q <= 1'b0;
					end
					if (t_q >= 17'(BIT_CYC - 1)) begin
						t_q <= 17'h00000;
						drv_low_q <= 1'b1;
						w_q <= {1'b0, w_q[23:1]};
						n_q <= n_q + 5'h01;
						if (n_q == 5'h17) begin
							st_q <= MS_EOS;
						end
					end
				end
				MS_EOS: begin
					// held low through eos and validation delay, released a fixed 12 cycles after that delay
					if (t_q >= 17'(ACK_VAL_CYC + 12)) begin
						t_q <= 17'h00000;
						drv_low_q <= 1'b0;
						st_q <= MS_SAMP;
					end
				end
				MS_SAMP: begin
					if (t_q >= 17'h00008) begin
						acked_q <= !s2_q;
						st_q <= MS_WAIT;
					end
				end
				MS_WAIT: begin
					if (t_q >= 17'(ACK_PULSE_CYC + 16)) begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= MS_IDLE;
					end
				end
				default: begin
					st_q <= MS_IDLE;
				end
			endcase
		end
	end

	assign link.mst_o = 1'b0;
	assign link.mst_oe_n = !drv_low_q;
	assign busy = busy_q;
	assign acked = acked_q;
	assign done = done_q;
endmodule
`default_nettype wire

// ---- core/owr_pkg.sv ----
// Purpose: shared constants for the one-wire brightness command link
// Assumes: 125 MHz clock, 8 ns period
// Notes: both ends import this package; the edge helper does not
package owr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned START_TIME_NS = 2000;
	localparam int unsigned END_OF_STREAM_TIME_NS = 2000;
	localparam int unsigned ACK_PULSE_TIME_US = 512;
	localparam int unsigned ACK_VALIDATION_DELAY_NS = 2000;
	// a zero's low phase must stay well under the end-of-stream time
	localparam int unsigned BIT_TIME_NS = 2400;
	// least times round up, longest times round down
	localparam int unsigned START_CYC = (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EOS_CYC = (END_OF_STREAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ACK_PULSE_CYC = (ACK_PULSE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned ACK_VAL_CYC = (ACK_VALIDATION_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned CMD_BITS = 24;
	localparam int unsigned CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam int unsigned ACK_REQ_POS = 10;
	localparam int unsigned BRIGHT_MSB_POS = 8;
	localparam int unsigned BRIGHT_LSB_POS = 0;
	localparam int unsigned ADDR_LSB_POS = 16;
	localparam logic [7:0] DEV_ADDR = 8'h8F;
	localparam logic [8:0] BRIGHT_RST = 9'h000;
	localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
	localparam logic [4:0] BIT_CNT_FULL = 5'h18;
endpackage

// ---- core/owr_sync_edge.sv ----
// Purpose: two-flop synchroniser with falling-edge detect
// Assumes: input is asynchronous to clk
// Notes: first flop feeds only the second
`timescale 1ns/1ns
`default_nettype none
module owr_sync_edge (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic din,
	output logic dout,
	output logic fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign dout = s2_q;
	assign fall = s3_q && !s2_q;
endmodule
`default_nettype wire

// ---- sim/owr_link_props.sv ----
// Purpose: temporal checks on the one-wire link between both ends
// Assumes: one clock, asynchronous active-high reset
// Notes: hi_cnt, lo_cnt and ok_cnt saturate so long idles never wrap; pd_cnt clears whenever dev_oe_n is high
`timescale 1ns/1ns
`default_nettype none
module owr_link_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic mst_oe_n,
	input wire logic dev_o,
	input wire logic dev_oe_n,
	input wire logic line,
	input wire logic frame_ok,
	input wire logic ack_busy,
	input wire logic [8:0] brightness
);
	import owr_pkg::*;
	int unsigned hi_cnt, lo_cnt, pd_cnt, ok_cnt;
	logic open_q;
	// ********************
	// helper counters
	// ********************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
		end else begin
			hi_cnt <= line ? ((hi_cnt < 99999) ? hi_cnt + 1 : hi_cnt) : 0;
			lo_cnt <= !line ? ((lo_cnt < 99999) ? lo_cnt + 1 : lo_cnt) : 0;
		end
	end
	// a frame is open from its first fall until an end-of-stream low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			open_q <= 1'b0;
		end else begin
			open_q <= (!line && hi_cnt != 0) ? 1'b1 : (lo_cnt >= EOS_CYC) ? 1'b0 : open_q;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pd_cnt <= 0;
		end else begin
			pd_cnt <= dev_oe_n ? 0 : pd_cnt + 1;
		end
	end
	// no frame yet reads as far away, so an early pull-down fails
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ok_cnt <= 99999;
		end else begin
			ok_cnt <= frame_ok ? 0 : ((ok_cnt < 99999) ? ok_cnt + 1 : ok_cnt);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_ack_on;
		$fell(dev_oe_n);
	endsequence
	sequence s_master_off;
		mst_oe_n [*8];
	endsequence
	a_start_high: assert property ($fell(line) && !open_q |-> hi_cnt >= START_CYC)
		else $error("line fell without a long enough high phase");
	a_eos_frame: assert property (frame_ok |-> lo_cnt >= EOS_CYC)
		else $error("frame accepted before end of stream");
	a_ok_pulse: assert property (frame_ok |=> !frame_ok)
		else $error("frame_ok longer than one cycle");
	a_bright_hold: assert property ($changed(brightness) |-> frame_ok || $past(frame_ok))
		else $error("brightness changed without an accepted frame");
	a_ack_timing: assert property (s_ack_on |-> !line && ok_cnt <= 3 && lo_cnt >= ACK_VAL_CYC)
		else $error("pull-down not tied to an accepted frame");
	a_ack_length: assert property (!dev_oe_n |-> pd_cnt < ACK_PULSE_CYC)
		else $error("acknowledge pull-down too long");
	a_ack_full: assert property ($rose(dev_oe_n) |-> pd_cnt >= ACK_PULSE_CYC - 2)
		else $error("acknowledge pull-down too short");
	a_ack_busy: assert property (!dev_oe_n |-> ack_busy && dev_o == 1'b0)
		else $error("pull-down without ack_busy");
	a_master_releases: assert property (s_ack_on |-> ##[0:20] s_master_off)
		else $error("master still drives during acknowledge");
endmodule
`default_nettype wire

// ---- sim/tb_one_wire_dimming_command_rx.sv ----
// Purpose: both ends joined on one link, one device on a bench-driven link
// Assumes: 125 MHz clock, open-drain line with pull-up
// Notes: the acknowledged frame alone takes about 72k cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tb_one_wire_dimming_command_rx;
	import owr_pkg::*;
	logic clk = 0, rst = 1, ce = 1, send = 0, ack_req = 0, line_q = 1;
	logic [8:0] level = 9'h000;
	logic [8:0] bright_a, bright_b;
	logic ok_a, ok_b, busy_a, busy_b, busy, acked, done;
	logic [23:0] wire_word = 24'h000000;
	int failures = 0, num_checks = 0, ok_cnt_a = 0, ok_cnt_b = 0, ack_cnt_b = 0;
	int nb = 0, lo = 0, hi = 0;
	// bench frames: wrong address, short, no start, long
	logic [31:0] cmd_t [4] = '{32'h008E0455, 32'h008F04AA, 32'h008F01FF, 32'h018F0133};
	int nb_t [4] = '{24, 23, 24, 25};
	int st_t [4] = '{300, 300, 0, 300};
	int okn_t [4] = '{0, 0, 1, 1};
	logic [8:0] br_t [4] = '{9'h000, 9'h000, 9'h1FF, 9'h1FF};
	owr_link_if link();
	owr_link_if link2();
	always #4 clk = ~clk;
	owr_device i_owr_device (.clk(clk), .rst(rst), .ce(ce), .link(link.device),
		.brightness(bright_a), .frame_ok(ok_a), .ack_busy(busy_a));
	owr_master i_owr_master (.clk(clk), .rst(rst), .ce(ce), .link(link.master), .send(send),
		.level(level), .ack_req(ack_req), .busy(busy), .acked(acked), .done(done));
	owr_device i_owr_device_flt (.clk(clk), .rst(rst), .ce(ce), .link(link2.device),
		.brightness(bright_b), .frame_ok(ok_b), .ack_busy(busy_b));
	owr_link_props i_props (.clk(clk), .rst(rst), .mst_oe_n(link.mst_oe_n), .dev_o(link.dev_o),
		.dev_oe_n(link.dev_oe_n), .line(link.line), .frame_ok(ok_a), .ack_busy(busy_a),
		.brightness(bright_a));
	// ********************
	// wire monitor and sequence
	// ********************
	// a bit is closed by the next fall; falls after a long low start a frame
	always @(negedge clk) begin
		if (ok_a === 1'b1) ok_cnt_a++;
		if (ok_b === 1'b1) ok_cnt_b++;
		if (link2.dev_oe_n === 1'b0) ack_cnt_b++;
		if (link.line === 1'b0 && line_q === 1'b1) begin
			if (lo > 0 && lo < EOS_CYC) begin
				wire_word = {hi >= 2 * lo, wire_word[23:1]};
				nb++;
			end
			lo = 0;
			hi = 0;
		end else if (link.line === 1'b0) lo++;
		else hi++;
		line_q = link.line;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task frame_b(input logic [31:0] c, input int n, input int st);
		int i;
		repeat (st) @(posedge clk);
		for (i = 0; i < n; i++) begin
			link2.mst_oe_n <= 1'b0;
			repeat (c[i] ? 40 : 120) @(posedge clk);
			link2.mst_oe_n <= 1'b1;
			repeat (c[i] ? 120 : 40) @(posedge clk);
		end
		link2.mst_oe_n <= 1'b0;
		repeat (300) @(posedge clk);
		link2.mst_oe_n <= 1'b1;
		repeat (20) @(posedge clk);
	endtask
	initial begin
		int i, n;
		link2.mst_o = 1'b0;
		link2.mst_oe_n = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			frame_b(cmd_t[i], nb_t[i], st_t[i]);
			`CHK(bright_b, br_t[i])
			`CHK(ok_cnt_b, okn_t[i])
			$display("bench frame %0d done", i);
		end
		`CHK(ack_cnt_b, 0)
		send <= 1'b1;
		level <= 9'h1A5;
		ack_req <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		for (n = 0; n < 80000 && done !== 1'b1; n++) @(negedge clk);
		`CHK(n < 80000, 1'b1)
		`CHK(acked, 1'b1)
		`CHK(bright_a, 9'h1A5)
		`CHK(wire_word, {8'h8F, 5'h00, 1'b1, 1'b0, 9'h1A5})
		`CHK(nb, 24)
		`CHK(ok_cnt_a, 1)
		$display("acknowledged frame done");
		complete_run();
	end
endmodule
`default_nettype wire
